// ===== verilog/ifel_pkg.sv
package ifel_pkg;

  // Register select codes
  localparam logic [3:0] SHIFT_DATA_OFF = 4'ha;
  localparam logic [3:0] PENDING_FLAG_OFF = 4'hd;
  localparam logic [3:0] MASK_OFF = 4'he;

  // Flag and enable field layout
  localparam int unsigned NUM_FLAGS = 7;
  localparam int unsigned FLAG_CTRL_A_TWO = 0;
  localparam int unsigned FLAG_CTRL_A_ONE = 1;
  localparam int unsigned FLAG_SHIFT = 2;
  localparam int unsigned FLAG_CTRL_B_TWO = 3;
  localparam int unsigned FLAG_CTRL_B_ONE = 4;
  localparam int unsigned TOP_BIT = 7;

  // Reset values
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [7:0] SHIFT_DATA_RST = 8'h00;
  localparam logic [7:0] READ_DATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Shift modes
  localparam logic [2:0] SHIFT_MODE_OFF = 3'h0;
  localparam logic [2:0] SHIFT_MODE_OUT_SYS = 3'h6;
  localparam logic [2:0] SHIFT_MODE_OUT_EXT = 3'h7;

  // Bits per shift group
  localparam logic [2:0] SHIFT_LAST_BIT = 3'h7;
  localparam logic [2:0] SHIFT_CNT_RST = 3'h0;

  typedef enum logic [0:0] {
    IFEL_SH_IDLE = 1'b0,
    IFEL_SH_RUN = 1'b1
  } ifel_shift_e;

endpackage

// ===== verilog/ifel_sync_if.sv
interface ifel_sync_if;
  logic raw;
  logic level;
  logic rise;

  modport user (
    output raw,
    input level,
    input rise
  );

  modport sync (
    input raw,
    output level,
    output rise
  );
endinterface

// ===== verilog/ifel_pin_sync.sv
module ifel_pin_sync (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  ifel_sync_if.sync pin
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // Three stage capture
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_reg <= 1'b1;
    end else if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign pin.level = level_reg;
  assign pin.rise = (s2_reg == s3_reg) && s3_reg && !level_reg;

endmodule // ifel_pin_sync

// ===== verilog/ifel_top.sv
// How it works
// - Mode 110 shifts out at half system clock rate
// - Mode 111: external pulse shifts; flag every eight
// - Mode 111: shift access clears flag, restarts count
// - Request asserted when any enabled flag set
// - Request line only pulls low or floats
// - Flags stay set until explicitly cleared, except the shift flag, held clear in mode 000
// - Flag read bit 7 shows live request
// - Flag write ones clear matching flags
// - Writing bit 7 of flags does nothing
// - Mask write, bit7 zero: ones clear enables
// - Mask write, bit7 one: ones set enables
// - Mask read: bit 7 one, enables below
// - Independent control line: port access keeps flag
// - Shift out msb first, rotated into bit0
module ifel_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic chip_sel_one_i,
  input wire logic chip_sel_two_n_i,
  input wire logic [3:0] register_select_lines_i,
  input wire logic read_not_write_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  input wire logic [2:0] shift_mode_i,
  input wire logic [6:0] flag_set_i,
  input wire logic port_a_output_reg_access_i,
  input wire logic port_b_output_reg_access_i,
  input wire logic port_a_ctrl_line_two_indep_i,
  input wire logic port_b_ctrl_line_two_indep_i,
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe_n_o,
  output logic port_b_ctrl_line_two_o,
  output logic port_b_ctrl_line_two_oe_n_o,
  output logic irq_req_o,
  output logic irq_req_oe_n_o
);

  ifel_sync_if sclk_sync ();

  logic bus_sel;
  logic bus_wr;
  logic bus_rd;
  logic sel_shift;
  logic sel_flags;
  logic sel_mask;
  logic shift_access;
  logic mode_sys;
  logic mode_ext;
  logic irq_active;
  logic shift_now;
  logic shift_done;
  logic last_bit;
  logic sys_running;
  logic phase_clear;
  logic shift_out_mode;
  logic shift_flag_off;
  logic wr_shift;
  logic wr_flags;
  logic wr_mask;
  logic rd_shift;
  logic rd_flags;
  logic rd_mask;
  logic rd_unmapped;
  logic [6:0] host_flag_clr;
  logic [6:0] port_flag_clr;
  logic [6:0] mask_register_next;
  logic [6:0] irq_terms;
  logic [7:0] rotated_data;
  logic [7:0] flag_read_word;
  logic [7:0] mask_read_word;
  logic [7:0] read_next;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic [6:0] pending_flag_register_reg;
  logic [6:0] pending_flag_register_next;
  logic [6:0] mask_register_reg;
  logic [7:0] shift_data_reg;
  logic [2:0] bit_cnt_reg;
  logic phase_reg;
  logic sclk_out_reg;
  logic [7:0] data_o_reg;
  ifel_pkg::ifel_shift_e shift_state_reg;

  ifel_pin_sync u_sclk_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pin(sclk_sync)
  );

  assign sclk_sync.raw = shift_clock_pin_i;

  // Bus decode; one access per selected clock
  assign bus_sel = chip_sel_one_i && !chip_sel_two_n_i;
  assign bus_wr = bus_sel && !read_not_write_i;
  assign bus_rd = bus_sel && read_not_write_i;
  assign sel_shift = register_select_lines_i == ifel_pkg::SHIFT_DATA_OFF;
  assign sel_flags = register_select_lines_i == ifel_pkg::PENDING_FLAG_OFF;
  assign sel_mask = register_select_lines_i == ifel_pkg::MASK_OFF;
  assign shift_access = bus_sel && sel_shift;

  // Per register strobes
  assign wr_shift = bus_wr && sel_shift;
  assign wr_flags = bus_wr && sel_flags;
  assign wr_mask = bus_wr && sel_mask;
  assign rd_shift = bus_rd && sel_shift;
  assign rd_flags = bus_rd && sel_flags;
  assign rd_mask = bus_rd && sel_mask;
  assign rd_unmapped = bus_rd && !(sel_shift || sel_flags || sel_mask);

  // Shift mode decode
  assign mode_sys = shift_mode_i == ifel_pkg::SHIFT_MODE_OUT_SYS;
  assign mode_ext = shift_mode_i == ifel_pkg::SHIFT_MODE_OUT_EXT;
  assign shift_out_mode = mode_sys || mode_ext;
  assign shift_flag_off = shift_mode_i == ifel_pkg::SHIFT_MODE_OFF;
  assign sys_running = mode_sys && !shift_access && shift_state_reg == ifel_pkg::IFEL_SH_RUN;
  assign phase_clear = shift_access || shift_state_reg == ifel_pkg::IFEL_SH_IDLE;
  assign last_bit = bit_cnt_reg == ifel_pkg::SHIFT_LAST_BIT;
  assign rotated_data = {shift_data_reg[6:0], shift_data_reg[7]};

  // Shift sequencing state
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_state_reg <= ifel_pkg::IFEL_SH_IDLE;
    end else if (!mode_sys) begin
      shift_state_reg <= ifel_pkg::IFEL_SH_IDLE;
    end else if (shift_access) begin
      shift_state_reg <= ifel_pkg::IFEL_SH_RUN;
    end else begin
      unique case (shift_state_reg)
        ifel_pkg::IFEL_SH_IDLE: begin
          shift_state_reg <= ifel_pkg::IFEL_SH_IDLE;
        end
        ifel_pkg::IFEL_SH_RUN: begin
          if (shift_now && last_bit) begin
            shift_state_reg <= ifel_pkg::IFEL_SH_IDLE;
          end
        end
      endcase
    end
  end

  // Half period phase of the generated shift clock
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_reg <= 1'b0;
    end else if (phase_clear) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
    end
  end

  // Shift strobe per mode
  always_comb begin
    shift_now = 1'b0;
    if (mode_sys) begin
      shift_now = sys_running && phase_reg;
    end else if (mode_ext) begin
      shift_now = sclk_sync.rise;
    end
  end

  assign shift_done = shift_now && last_bit;

  // Bit counter
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_reg <= ifel_pkg::SHIFT_CNT_RST;
    end else if (shift_access) begin
      bit_cnt_reg <= ifel_pkg::SHIFT_CNT_RST;
    end else if (shift_now) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Shift data register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_data_reg <= ifel_pkg::SHIFT_DATA_RST;
    end else if (wr_shift) begin
      shift_data_reg <= data_i;
    end else if (shift_now) begin
      shift_data_reg <= rotated_data;
    end
  end

  // Generated shift clock, low in the second half of each bit
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_out_reg <= 1'b1;
    end else if (sys_running) begin
      sclk_out_reg <= phase_reg;
    end else begin
      sclk_out_reg <= 1'b1;
    end
  end

  assign shift_clock_pin_o = sclk_out_reg;
  assign shift_clock_pin_oe_n_o = !mode_sys;
  assign port_b_ctrl_line_two_o = shift_data_reg[7];
  assign port_b_ctrl_line_two_oe_n_o = !shift_out_mode;

  // Host write clears; bit 7 holds no flag
  assign host_flag_clr = wr_flags ? data_i[6:0] : 7'h00;

  // Port output register accesses clear line flags
  always_comb begin
    port_flag_clr = 7'h00;
    if (port_a_output_reg_access_i) begin
      port_flag_clr[ifel_pkg::FLAG_CTRL_A_ONE] = 1'b1;
      if (!port_a_ctrl_line_two_indep_i) begin
        port_flag_clr[ifel_pkg::FLAG_CTRL_A_TWO] = 1'b1;
      end
    end
    if (port_b_output_reg_access_i) begin
      port_flag_clr[ifel_pkg::FLAG_CTRL_B_ONE] = 1'b1;
      if (!port_b_ctrl_line_two_indep_i) begin
        port_flag_clr[ifel_pkg::FLAG_CTRL_B_TWO] = 1'b1;
      end
    end
  end

  // Flag set and clear terms; set wins
  always_comb begin
    flag_set = flag_set_i;
    flag_clr = host_flag_clr | port_flag_clr;
    if (shift_out_mode) begin
      flag_set[ifel_pkg::FLAG_SHIFT] = shift_done;
    end
    if (shift_access) begin
      flag_clr[ifel_pkg::FLAG_SHIFT] = 1'b1;
    end
    pending_flag_register_next = (pending_flag_register_reg & ~flag_clr) | flag_set;
    if (shift_flag_off) begin
      pending_flag_register_next[ifel_pkg::FLAG_SHIFT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_flag_register_reg <= ifel_pkg::FLAGS_RST;
    end else begin
      pending_flag_register_reg <= pending_flag_register_next;
    end
  end

  // Enable mask, set or clear by bit 7
  always_comb begin
    mask_register_next = mask_register_reg;
    if (wr_mask) begin
      if (data_i[ifel_pkg::TOP_BIT]) begin
        mask_register_next = mask_register_reg | data_i[6:0];
      end else begin
        mask_register_next = mask_register_reg & ~data_i[6:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_register_reg <= ifel_pkg::MASK_RST;
    end else begin
      mask_register_reg <= mask_register_next;
    end
  end

  // Combined request
  assign irq_terms = pending_flag_register_reg & mask_register_reg;
  assign irq_active = |irq_terms;
  assign irq_req_o = 1'b0;
  assign irq_req_oe_n_o = !irq_active;

  assign flag_read_word = {irq_active, pending_flag_register_reg};
  assign mask_read_word = {1'b1, mask_register_reg};

  // Read mux; holds the last read otherwise
  always_comb begin
    read_next = data_o_reg;
    if (rd_flags) begin
      read_next = flag_read_word;
    end else if (rd_mask) begin
      read_next = mask_read_word;
    end else if (rd_shift) begin
      read_next = shift_data_reg;
    end else if (rd_unmapped) begin
      read_next = ifel_pkg::UNMAPPED_READ;
    end
  end

  // Read data, captured at the access edge
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o_reg <= ifel_pkg::READ_DATA_RST;
    end else begin
      data_o_reg <= read_next;
    end
  end

  assign data_o = data_o_reg;

endmodule // ifel_top

// ===== verification/ifel_monitor.sv
module ifel_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic chip_sel_one_i,
  input wire logic chip_sel_two_n_i,
  input wire logic [3:0] register_select_lines_i,
  input wire logic read_not_write_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic [2:0] shift_mode_i,
  input wire logic [6:0] flag_set_i,
  input wire logic shift_clock_pin_o,
  input wire logic shift_clock_pin_oe_n_o,
  input wire logic irq_req_o,
  input wire logic irq_req_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd, wr;
  logic [3:0] rs;
  assign rd = chip_sel_one_i & !chip_sel_two_n_i & read_not_write_i;
  assign wr = chip_sel_one_i & !chip_sel_two_n_i & !read_not_write_i;
  assign rs = register_select_lines_i;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  irq_no_high_a: assert property (irq_req_o == 1'b0) else $error("irq driven high");
  rst_release_a: assert property ($rose(nrst_i) |-> irq_req_oe_n_o) else $error("irq after reset");
  mask_clear_a: assert property (wr && rs == 4'he && data_i == 8'h7f |=> irq_req_oe_n_o) else $error("mask clr");
  flag_clear_a: assert property (wr && rs == 4'hd && data_i[6:0] == 7'h7f && flag_set_i == 7'h00
    && shift_mode_i == 3'h0 |=> irq_req_oe_n_o) else $error("flag clr");
  flag_top_a: assert property (rd && rs == 4'hd |=> data_o[7] == !$past(irq_req_oe_n_o)) else $error("flag b7");
  mask_top_a: assert property (rd && rs == 4'he |=> data_o[7]) else $error("mask b7");
  irq_or_a: assert property ((rd && rs == 4'he) ##1 (rd && rs == 4'hd) |=>
    (|(data_o[6:0] & $past(data_o[6:0]))) == !$past(irq_req_oe_n_o)) else $error("irq or");
  sys_clock_a: assert property (shift_mode_i == 3'h6 && (rd || wr) && rs == 4'ha |=>
    !shift_clock_pin_oe_n_o ##[0:2] !shift_clock_pin_o) else $error("sys clock");
  cover property (!irq_req_oe_n_o);
  cover property (shift_mode_i == 3'h7 && rd && rs == 4'ha);
  cover property (shift_mode_i == 3'h6 && $fell(shift_clock_pin_o));
endmodule // ifel_monitor

// ===== verification/ifel_host_model.sv
module ifel_host_model (
  input wire logic core_clk_i,
  output logic cs_o,
  output logic [3:0] rs_o,
  output logic rnw_o,
  output logic [7:0] wd_o,
  input wire logic [7:0] rd_i,
  input wire logic irq_i,
  input wire logic irq_oe_n_i,
  output logic sclk_o,
  output wire logic irq_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared request line with pull-up
  assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_i;
  initial begin
    cs_o = 1'b0;
    rs_o = 4'h0;
    rnw_o = 1'b1;
    wd_o = 8'h00;
    sclk_o = 1'b1;
  end
  task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] w, output logic [7:0] d);
    cs_o <= 1'b1;
    rnw_o <= r;
    rs_o <= a;
    wd_o <= w;
    @(posedge core_clk_i);
    #1 d = rd_i;
  endtask
  task automatic idle();
    cs_o <= 1'b0;
    wd_o <= ~wd_o;
  endtask
  // External shift clock, idle high
  task automatic pulses(input int n);
    idle();
    repeat (n) begin
      repeat (3) @(posedge core_clk_i);
      #1 sclk_o <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1 sclk_o <= 1'b1;
    end
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
endmodule // ifel_host_model

// ===== verification/test_ifel_top.sv
module test_ifel_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cs, rnw, sclk, irq, irq_oe_n, irq_line, pa_acc, pb_acc, pa_ind, pb_ind, so, sd;
  logic cs2n, so_oe_n, sd_oe_n;
  logic [3:0] rs;
  logic [7:0] wd, rdat, d, ser, nfall;
  logic [2:0] mode;
  logic [6:0] fset;
  int num_errors, comparisons, cycles;
  ifel_top i_dut (.core_clk_i(clk), .nrst_i(nrst), .chip_sel_one_i(cs), .chip_sel_two_n_i(cs2n),
    .register_select_lines_i(rs), .read_not_write_i(rnw), .data_i(wd), .data_o(rdat), .shift_mode_i(mode),
    .flag_set_i(fset), .port_a_output_reg_access_i(pa_acc), .port_b_output_reg_access_i(pb_acc),
    .port_a_ctrl_line_two_indep_i(pa_ind), .port_b_ctrl_line_two_indep_i(pb_ind), .shift_clock_pin_i(sclk),
    .shift_clock_pin_o(so), .shift_clock_pin_oe_n_o(so_oe_n), .port_b_ctrl_line_two_o(sd),
    .port_b_ctrl_line_two_oe_n_o(sd_oe_n), .irq_req_o(irq), .irq_req_oe_n_o(irq_oe_n));
  ifel_host_model i_host (.core_clk_i(clk), .cs_o(cs), .rs_o(rs), .rnw_o(rnw), .wd_o(wd), .rd_i(rdat),
    .irq_i(irq), .irq_oe_n_i(irq_oe_n), .sclk_o(sclk), .irq_line_o(irq_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  always @(negedge so) begin
    ser <= {ser[6:0], sd};
    nfall <= nfall + 8'h01;
  end
  task automatic complete_run();
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    i_host.acc(1'b1, a, 8'h00, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_host.acc(1'b0, a, v, d);
  endtask
  task automatic cyc(input int n);
    i_host.idle();
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic port_pulse();
    pa_acc <= 1'b1;
    pb_acc <= 1'b1;
    cyc(1);
    pa_acc <= 1'b0;
    pb_acc <= 1'b0;
  endtask
  initial begin
    {nrst, cs2n, pa_acc, pb_acc, pa_ind, pb_ind} = 6'h00;
    {mode, fset, ser, nfall} = 26'h0;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    chk({7'h00, irq_line}, 8'h01);
    chk({6'h00, so_oe_n, sd_oe_n}, 8'h03);
    rd(4'hd, 8'h00);
    rd(4'he, 8'h80);
    cs2n <= 1'b1;
    wr(4'he, 8'hff);
    cs2n <= 1'b0;
    rd(4'he, 8'h80);
    fset <= 7'h7f;
    cyc(1);
    fset <= 7'h00;
    cyc(4);
    rd(4'hd, 8'h7b);
    wr(4'he, 8'h90);
    rd(4'he, 8'h90);
    rd(4'hd, 8'hfb);
    chk({7'h00, irq_line}, 8'h00);
    wr(4'hd, 8'h80);
    rd(4'hd, 8'hfb);
    wr(4'hd, 8'h10);
    rd(4'hd, 8'h6b);
    wr(4'he, 8'h88);
    rd(4'hd, 8'heb);
    wr(4'he, 8'h08);
    rd(4'he, 8'h90);
    wr(4'he, 8'h7f);
    rd(4'he, 8'h80);
    pa_ind <= 1'b1;
    pb_ind <= 1'b1;
    port_pulse();
    rd(4'hd, 8'h69);
    pa_ind <= 1'b0;
    pb_ind <= 1'b0;
    port_pulse();
    rd(4'hd, 8'h60);
    wr(4'hd, 8'h7f);
    rd(4'hd, 8'h00);
    rd(4'h3, 8'h00);
    mode <= 3'h6;
    wr(4'he, 8'h84);
    wr(4'ha, 8'hb4);
    chk({6'h00, so_oe_n, sd_oe_n}, 8'h00);
    cyc(24);
    chk(ser, 8'hb4);
    chk(nfall, 8'h08);
    rd(4'hd, 8'h84);
    rd(4'ha, 8'hb4);
    cyc(20);
    mode <= 3'h7;
    wr(4'ha, 8'h5a);
    chk({6'h00, so_oe_n, sd_oe_n}, 8'h02);
    i_host.pulses(7);
    rd(4'hd, 8'h00);
    i_host.pulses(1);
    rd(4'hd, 8'h84);
    chk({7'h00, irq_line}, 8'h00);
    rd(4'ha, 8'h5a);
    rd(4'hd, 8'h00);
    i_host.pulses(4);
    wr(4'ha, 8'hc3);
    i_host.pulses(4);
    rd(4'hd, 8'h00);
    i_host.pulses(4);
    rd(4'hd, 8'h84);
    rd(4'ha, 8'hc3);
    fset <= 7'h01;
    wr(4'he, 8'h81);
    fset <= 7'h00;
    chk({7'h00, irq_line}, 8'h00);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    chk({6'h00, so_oe_n, irq_line}, 8'h03);
    rd(4'hd, 8'h00);
    rd(4'he, 8'h80);
    mode <= 3'h0;
    cyc(2);
    complete_run();
  end
endmodule // test_ifel_top
bind ifel_top ifel_monitor i_mon (.core_clk_i, .nrst_i, .chip_sel_one_i, .chip_sel_two_n_i,
  .register_select_lines_i, .read_not_write_i, .data_i, .data_o, .shift_mode_i, .flag_set_i,
  .shift_clock_pin_o, .shift_clock_pin_oe_n_o, .irq_req_o, .irq_req_oe_n_o);
